/* File: design/power_monitor_params.svh */
// Register offsets, field positions, reset values, write mask and reserved bit count
`ifndef POWER_MONITOR_PARAMS_SVH
`define POWER_MONITOR_PARAMS_SVH

`define ADDR_SHUNT_VOLTAGE 6'h04
`define ADDR_BUS_VOLTAGE 6'h05
`define ADDR_DIE_TEMP 6'h06
`define ADDR_CURRENT 6'h07
`define ADDR_POWER 6'h08
`define ADDR_ENERGY 6'h09
`define ADDR_CHARGE 6'h0A
`define ADDR_DIAG_ALERT 6'h0B

`define BIT_ALERT_LATCH 15
`define BIT_CONV_DONE_ALERT 14
`define BIT_AVERAGED_COMPARE 13
`define BIT_ALERT_POLARITY 12
`define BIT_ENERGY_OVERFLOW 11
`define BIT_CONV_DONE 1
`define BIT_MEM_OK 0

`define DIAG_RESET 16'h0001
`define DIAG_WRITE_MASK 16'hF000
`define RESERVED_LOW_BITS 4

`endif

/* File: design/power_monitor_pkg.sv */
// Types shared by the power monitor result block
package power_monitor_pkg;
	typedef enum logic [1:0] {
		ACC_IDLE,
		ACC_SHIFT
	} access_state_t;
	typedef logic [39:0] reg_word_t;
endpackage

/* File: design/result_store.sv */
// Small result memory: one 40-bit word per result, registered read data
`timescale 1ns/100ps
module result_store #(
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	// Clock
	input wire logic clock,
	// Write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [39:0] wr_data,
	// Read side
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [39:0] rd_data
);
	logic [39:0] mem [DEPTH];

	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clock) begin
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

/* File: design/power_monitor_results.sv */
// Result registers and diagnostic/alert register of the power monitor
//
// Overview of operation
// - Shunt voltage: 20-bit signed in bits 23..4, scale set by input range.
// - Bus voltage: 20-bit field in bits 23..4, never negative.
// - Die temperature: 16-bit signed, whole register.
// - Current: 20-bit signed in bits 23..4 of 24-bit register.
// - Power: 24-bit unsigned in bits 23..0.
// - Energy: 40-bit unsigned in bits 39..0.
// - Charge: 40-bit signed, either direction of flow.
// - Low four bits of shunt, bus and current read as zero.
// - Latch off: alert follows fault, clears when it goes.
// - Latch on: alert holds until diagnostic register read.
// - Bit 14 set routes conversion-done flag onto the alert output.
// - Bit 13 chooses raw sample or averaged value for limit compare.
// - Bit 12 sets alert polarity: 0 active low, 1 active high.
// - Energy overflow flag bit 11 set on overflow, cleared on energy read.
// - Diagnostic register resets to 0001h, alert configuration cleared.
// - With averaging above one, results update only after averaging ends.
// - Conversion-done flag sets at finish; latched clear on read or trigger.
`timescale 1ns/100ps
`include "power_monitor_params.svh"
module power_monitor_results
	import power_monitor_pkg::*;
#(
	parameter int ADDR_W = 6
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Host register port: byte-serial read, word write
	input wire logic host_rd_start,
	input wire logic host_rd_next,
	input wire logic [ADDR_W-1:0] host_addr,
	input wire logic host_wr,
	input wire logic [15:0] host_wr_data,
	output logic [7:0] host_rd_byte,
	output logic host_rd_valid,
	// Measurement engine
	input wire logic [19:0] shunt_sample,
	input wire logic [19:0] bus_sample,
	input wire logic [15:0] temp_sample,
	input wire logic [19:0] current_sample,
	input wire logic [23:0] power_sample,
	input wire logic [39:0] energy_sample,
	input wire logic [39:0] charge_sample,
	input wire logic sample_valid,
	input wire logic average_done,
	input wire logic [2:0] averaging_count,
	input wire logic input_range_select,
	input wire logic energy_overflow_event,
	input wire logic triggered_start,
	// Limit comparator results
	input wire logic raw_limit_fault,
	input wire logic avg_limit_fault,
	// Alert pin, open drain
	output logic alert_out,
	output logic alert_oe,
	// Configuration seen by the engine
	output logic averaged_compare_select,
	output logic input_range_q
);
	// =========================================================
	// Result capture
	logic upd;
	logic [2:0] cap_idx_r;
	logic cap_busy_r;
	reg_word_t cap_word;
	reg_word_t snap_r [7];
	logic [39:0] store_rd;
	logic store_rd_en;
	logic [2:0] store_rd_addr;
	logic rd_pending_r;
	access_state_t acc_state_r;
	reg_word_t shift_r;
	logic [2:0] bytes_left_r;
	logic [15:0] diag_r;
	logic fault_latched_r;
	logic diag_read;
	logic energy_read;
	logic fault_now;
	logic alert_active;

	// Results may only move once averaging has finished; with averaging
	// on, the engine flags its last sample with average_done alongside
	assign upd = sample_valid
		&& (averaging_count == 3'h0 || average_done);

	// Twenty-bit results sit above a low nibble that always reads zero
	function automatic reg_word_t pad20(input logic [19:0] v);
		pad20 = {16'h0000, v, 4'h0};
	endfunction

	// Snapshot all inputs in one cycle, then copy into store one by one
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			for (int i = 0; i < 7; i++) begin
				snap_r[i] <= '0;
			end
		end else if (upd && !cap_busy_r) begin
			snap_r[0] <= pad20(shunt_sample);
			snap_r[1] <= pad20(bus_sample[19] ? 20'h00000 : bus_sample);
			snap_r[2] <= {24'h000000, temp_sample};
			snap_r[3] <= pad20(current_sample);
			snap_r[4] <= {16'h0000, power_sample};
			snap_r[5] <= energy_sample;
			snap_r[6] <= charge_sample;
		end
	end

	// One copy walk takes seven cycles; an update that lands during it is
	// dropped, trading a lost sample for a store that never holds a torn set
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			// Walk once out of reset so all seven result words in the store start at zero
			cap_busy_r <= 1'b1;
			cap_idx_r <= 3'h0;
		end else if (cap_busy_r) begin
			if (cap_idx_r == 3'h6) begin
				cap_busy_r <= 1'b0;
			end
			cap_idx_r <= (cap_idx_r == 3'h6) ? 3'h0 : cap_idx_r + 3'h1;
		end else if (upd) begin
			cap_busy_r <= 1'b1;
			cap_idx_r <= 3'h0;
		end
	end

	assign cap_word = snap_r[cap_idx_r];

	// =========================================================
	// Result store
	// Store read waits while a copy is running; reads see whole words
	assign store_rd_en = rd_pending_r && !cap_busy_r;
	// Store slots count from the shunt result offset
	assign store_rd_addr = 3'(host_addr - `ADDR_SHUNT_VOLTAGE);

	result_store #(.DEPTH(8), .AW(3)) u_store (
		.clock(clock),
		.wr_en(cap_busy_r),
		.wr_addr(cap_idx_r),
		.wr_data(cap_word),
		.rd_en(store_rd_en),
		.rd_addr(store_rd_addr),
		.rd_data(store_rd)
	);

	// =========================================================
	// Host access
	// Register width in bytes; unmapped offsets return one zero byte
	function automatic logic [2:0] reg_bytes(input logic [ADDR_W-1:0] a);
		if (a == ADDR_W'(`ADDR_DIE_TEMP)
			|| a == ADDR_W'(`ADDR_DIAG_ALERT)) begin
			reg_bytes = 3'h2;
		end else if (a == ADDR_W'(`ADDR_ENERGY)
			|| a == ADDR_W'(`ADDR_CHARGE)) begin
			reg_bytes = 3'h5;
		end else if (a >= ADDR_W'(`ADDR_SHUNT_VOLTAGE)
			&& a < ADDR_W'(`ADDR_DIAG_ALERT)) begin
			reg_bytes = 3'h3;
		end else begin
			reg_bytes = 3'h1;
		end
	endfunction

	logic is_result;
	assign is_result = host_addr >= ADDR_W'(`ADDR_SHUNT_VOLTAGE)
		&& host_addr < ADDR_W'(`ADDR_DIAG_ALERT);

	// A result read is parked here until the copy walk lets it through
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rd_pending_r <= 1'b0;
		end else if (host_rd_start && is_result) begin
			rd_pending_r <= 1'b1;
		end else if (store_rd_en) begin
			rd_pending_r <= 1'b0;
		end
	end

	logic load_store;
	logic load_direct;
	assign load_store = store_rd_en;
	assign load_direct = host_rd_start && !is_result;
	assign diag_read = load_direct && host_addr == ADDR_W'(`ADDR_DIAG_ALERT);
	assign energy_read = load_store && host_addr == ADDR_W'(`ADDR_ENERGY);

	logic load_q_r;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			load_q_r <= 1'b0;
		end else begin
			load_q_r <= load_store;
		end
	end

	// Byte stream, most significant byte first
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			acc_state_r <= ACC_IDLE;
			shift_r <= '0;
			bytes_left_r <= 3'h0;
			host_rd_byte <= 8'h00;
			host_rd_valid <= 1'b0;
		end else begin
			host_rd_valid <= 1'b0;
			unique case (acc_state_r)
				ACC_IDLE: begin
					if (load_q_r) begin
						shift_r <= store_rd << (8 * (5 - reg_bytes(host_addr)));
						bytes_left_r <= reg_bytes(host_addr);
						acc_state_r <= ACC_SHIFT;
					end else if (load_direct) begin
						shift_r <= (host_addr == ADDR_W'(`ADDR_DIAG_ALERT))
							? {diag_r, 24'h000000} : '0;
						bytes_left_r <= reg_bytes(host_addr);
						acc_state_r <= ACC_SHIFT;
					end
				end
				ACC_SHIFT: begin
					// First byte leaves unasked; later ones wait for a request
					if (bytes_left_r == 3'h0) begin
						acc_state_r <= ACC_IDLE;
					end else if (host_rd_next
						|| bytes_left_r == reg_bytes(host_addr)) begin
						host_rd_byte <= shift_r[39:32];
						host_rd_valid <= 1'b1;
						shift_r <= shift_r << 8;
						bytes_left_r <= bytes_left_r - 3'h1;
					end
				end
			endcase
		end
	end

	// =========================================================
	// Diagnostic and alert register
	assign fault_now = diag_r[`BIT_AVERAGED_COMPARE] ? avg_limit_fault
		: raw_limit_fault;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			diag_r <= `DIAG_RESET;
		end else begin
			// Only configuration bits are writable; results ignore writes
			if (host_wr && host_addr == ADDR_W'(`ADDR_DIAG_ALERT)) begin
				diag_r[15:12] <= host_wr_data[15:12];
			end
			// An overflow in the cycle of an energy read wins over the clear
			if (energy_overflow_event) begin
				diag_r[`BIT_ENERGY_OVERFLOW] <= 1'b1;
			end else if (energy_read) begin
				diag_r[`BIT_ENERGY_OVERFLOW] <= 1'b0;
			end
			if (upd) begin
				diag_r[`BIT_CONV_DONE] <= 1'b1;
			end else if (diag_r[`BIT_ALERT_LATCH]) begin
				if (diag_read || triggered_start) begin
					diag_r[`BIT_CONV_DONE] <= 1'b0;
				end
			end else if (triggered_start) begin
				// Transparent mode keeps the flag until a triggered start
				diag_r[`BIT_CONV_DONE] <= 1'b0;
			end
		end
	end

	// With the latch bit set, a fault holds until the diagnostic register is read; with it clear it follows the fault
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			fault_latched_r <= 1'b0;
		end else if (fault_now) begin
			fault_latched_r <= 1'b1;
		end else if (!diag_r[`BIT_ALERT_LATCH] || diag_read) begin
			fault_latched_r <= 1'b0;
		end
	end

	assign alert_active = fault_latched_r
		|| (diag_r[`BIT_CONV_DONE_ALERT] && diag_r[`BIT_CONV_DONE]);

	// =========================================================
	// Alert pin
	// Open drain: drive only when the pin must be low; with polarity one
	// the idle pin is held low and released while the alert is active
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			alert_out <= 1'b0;
			alert_oe <= 1'b0;
		end else begin
			alert_out <= 1'b0;
			alert_oe <= alert_active ^ diag_r[`BIT_ALERT_POLARITY];
		end
	end

	// =========================================================
	// Configuration copies for the engine
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			averaged_compare_select <= 1'b0;
			input_range_q <= 1'b0;
		end else begin
			averaged_compare_select <= diag_r[`BIT_AVERAGED_COMPARE];
			input_range_q <= input_range_select;
		end
	end
endmodule

/* File: tb/power_monitor_results_sva.sv */
// Checker for the ports of the power monitor result block
`timescale 1ns/100ps
module pm_results_sva (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Host port
	input wire logic host_rd_start,
	input wire logic host_rd_valid,
	input wire logic [5:0] host_addr,
	input wire logic host_wr,
	input wire logic [15:0] host_wr_data,
	input wire logic [7:0] host_rd_byte,
	// Engine and alert
	input wire logic sample_valid,
	input wire logic [2:0] averaging_count,
	input wire logic raw_limit_fault,
	input wire logic avg_limit_fault,
	input wire logic alert_out,
	input wire logic alert_oe,
	input wire logic averaged_compare_select
);
	logic [3:0] cfg_r;
	logic [2:0] nbyte_r;
	logic quiet;
	assign quiet = !raw_limit_fault && !avg_limit_fault;
	// Shadow of the configuration nibble, so checks know the mode
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cfg_r <= 4'h0;
		end else if (host_wr && host_addr == 6'h0B) begin
			cfg_r <= host_wr_data[15:12];
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst || host_rd_start) begin
			nbyte_r <= 3'h0;
		end else if (host_rd_valid) begin
			nbyte_r <= nbyte_r + 3'h1;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// ==========================================================
	// Properties
	property p_reset_idle;
		disable iff (1'h0) sys_rst |=> !alert_oe && !averaged_compare_select;
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("outputs not idle after reset");
	property p_open_drain;
		alert_out == 1'h0;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("alert pin driven high");
	property p_polarity;
		(cfg_r == 4'h1 && quiet) [*3] |-> alert_oe;
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("inverted polarity idle level wrong");
	property p_follow_set;
		(cfg_r == 4'h0 && raw_limit_fault) [*3] |-> alert_oe;
	endproperty
	a_follow_set: assert property (p_follow_set)
		else $error("alert missing during fault");
	property p_follow_clear;
		(cfg_r == 4'h0 && quiet) [*3] |-> !alert_oe;
	endproperty
	a_follow_clear: assert property (p_follow_clear)
		else $error("transparent alert did not clear");
	property p_avg_select;
		(cfg_r == 4'h2 && avg_limit_fault) [*3] |-> alert_oe;
	endproperty
	a_avg_select: assert property (p_avg_select)
		else $error("averaged fault ignored");
	property p_cfg_copy;
		averaged_compare_select == $past(cfg_r[1]);
	endproperty
	a_cfg_copy: assert property (p_cfg_copy)
		else $error("compare select copy wrong");
	property p_conv_alert;
		cfg_r == 4'h4 && sample_valid && averaging_count == 3'h0
			|-> ##[1:4] alert_oe;
	endproperty
	a_conv_alert: assert property (p_conv_alert)
		else $error("conversion done not on alert");
	property p_low_zero;
		host_rd_valid && nbyte_r == 3'h2 && (host_addr == 6'h04 ||
			host_addr == 6'h05 || host_addr == 6'h07) |-> host_rd_byte[3:0] == 4'h0;
	endproperty
	a_low_zero: assert property (p_low_zero)
		else $error("reserved low bits not zero");
endmodule

bind power_monitor_results pm_results_sva u_sva (.clock(clock),
	.sys_rst(sys_rst), .host_rd_start(host_rd_start),
	.host_rd_valid(host_rd_valid), .host_addr(host_addr), .host_wr(host_wr),
	.host_wr_data(host_wr_data), .host_rd_byte(host_rd_byte),
	.sample_valid(sample_valid), .averaging_count(averaging_count),
	.raw_limit_fault(raw_limit_fault), .avg_limit_fault(avg_limit_fault),
	.alert_out(alert_out), .alert_oe(alert_oe),
	.averaged_compare_select(averaged_compare_select));

/* File: tb/host_reader.sv */
// Host model issuing byte-serial reads and word writes
`timescale 1ns/100ps
module host_reader (
	// Clock
	input wire logic clock,
	// Register port
	output logic host_rd_start,
	output logic host_rd_next,
	output logic [5:0] host_addr,
	output logic host_wr,
	output logic [15:0] host_wr_data,
	input wire logic [7:0] host_rd_byte,
	input wire logic host_rd_valid
);
	initial begin
		{host_rd_start, host_rd_next, host_wr} = 3'h0;
		host_addr = 6'h00;
		host_wr_data = 16'h0000;
	end
	task automatic write(input logic [5:0] a, input logic [15:0] v);
		@(negedge clock);
		host_addr = a;
		host_wr_data = v;
		host_wr = 1'h1;
		@(negedge clock);
		host_wr = 1'h0;
	endtask
	task automatic read(input logic [5:0] a, input int n,
		output logic [39:0] d, output bit ok);
		int k;
		d = 40'h0;
		ok = 1;
		@(negedge clock);
		host_addr = a;
		host_rd_start = 1'h1;
		for (int i = 0; i < n; i++) begin
			k = 0;
			// Requests last one rising edge; the first byte may stall
			// behind the copy walk, so the wait is bounded
			do begin
				@(negedge clock);
				host_rd_start = 1'h0;
				k++;
			end while (host_rd_valid !== 1'h1 && k < 20);
			ok = ok && host_rd_valid === 1'h1;
			d = {d[31:0], host_rd_byte};
			host_rd_next = i < n - 1;
		end
		@(negedge clock);
	endtask
endmodule

/* File: tb/power_monitor_results_tb.sv */
// Self-checking bench for the power monitor result block
`timescale 1ns/100ps
module power_monitor_results_tb;
	logic clock = 0, sys_rst = 1, sample_valid = 0, average_done = 0;
	logic energy_overflow_event = 0, triggered_start = 0;
	logic raw_limit_fault = 0, avg_limit_fault = 0, input_range_select = 0;
	logic [2:0] averaging_count = 3'h0;
	logic [19:0] shunt_sample = 0, bus_sample = 0, current_sample = 0;
	logic [15:0] temp_sample = 0;
	logic [23:0] power_sample = 0;
	logic [39:0] energy_sample = 0, charge_sample = 0, d, old;
	wire logic host_rd_start, host_rd_next, host_wr, host_rd_valid;
	wire logic alert_out, alert_oe, range_q;
	wire logic [5:0] host_addr;
	wire logic [15:0] host_wr_data;
	wire logic [7:0] host_rd_byte;
	int bad_count = 0, checks = 0;
	bit ok;
	always #25 clock = ~clock;
	power_monitor_results DUT (.clock, .sys_rst, .host_rd_start, .host_rd_next,
		.host_addr, .host_wr, .host_wr_data, .host_rd_byte, .host_rd_valid,
		.shunt_sample, .bus_sample, .temp_sample, .current_sample,
		.power_sample, .energy_sample, .charge_sample, .sample_valid,
		.average_done, .averaging_count, .input_range_select,
		.energy_overflow_event, .triggered_start, .raw_limit_fault,
		.avg_limit_fault, .alert_out, .alert_oe, .averaged_compare_select(),
		.input_range_q(range_q));
	host_reader host (.clock, .host_rd_start, .host_rd_next, .host_addr,
		.host_wr, .host_wr_data, .host_rd_byte, .host_rd_valid);
	// ==========================================================
	// Expectations and helpers
	function automatic logic [39:0] expected(input int a);
		case (a)
			4: return {16'h0, shunt_sample, 4'h0};
			5: return {16'h0, bus_sample[19] ? 20'h0 : bus_sample, 4'h0};
			6: return {24'h0, temp_sample};
			7: return {16'h0, current_sample, 4'h0};
			8: return {16'h0, power_sample};
			9: return energy_sample;
			default: return charge_sample;
		endcase
	endfunction
	function automatic int nb(input int a);
		if (a < 4 || a > 11) return 1;
		return (a == 6 || a == 11) ? 2 : (a > 8 ? 5 : 3);
	endfunction
	task automatic check(input logic [39:0] seen, input logic [39:0] want);
		checks++;
		if (seen !== want) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic finish_test;
		$display("comparisons %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic rd(input int a, output logic [39:0] v);
		host.read(6'(a), nb(a), v, ok);
		if (!ok) begin
			bad_count++;
			finish_test();
		end
	endtask
	task automatic pulse(ref logic s);
		@(negedge clock);
		s = 1'h1;
		@(negedge clock);
		s = 1'h0;
	endtask
	task automatic hold(ref logic s, input int n);
		s = 1'h1;
		repeat (n) @(negedge clock);
		s = 1'h0;
		repeat (6) @(negedge clock);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(44));
		repeat (4) @(negedge clock);
		sys_rst = 0;
		repeat (8) @(negedge clock);
		for (int a = 4; a < 12; a++) begin
			rd(a, d);
			check(d, a == 11 ? 40'h1 : 40'h0);
		end
		rd(63, d);
		check(d, 40'h0);
		$display("test reset values done");
		for (int r = 0; r < 6; r++) begin
			shunt_sample = r == 1 ? 20'h80000 : 20'($urandom);
			bus_sample = r == 0 ? 20'h80000 : 20'($urandom);
			{temp_sample, current_sample, power_sample} = 60'({$urandom, $urandom});
			{energy_sample, charge_sample} = 80'({$urandom, $urandom, $urandom});
			input_range_select = r[0];
			pulse(sample_valid);
			host.write(6'(4 + r), 16'($urandom));
			check(40'(range_q), 40'(r[0]));
			for (int a = 4; a < 11; a++) begin
				// The first read lands inside the copy walk and must stall
				rd(a, d);
				check(d, expected(a));
			end
		end
		$display("test random results done");
		averaging_count = 3'h1;
		old = expected(4);
		shunt_sample = 20'h7FFFF;
		pulse(sample_valid);
		rd(4, d);
		check(d, old);
		// The last sample of an average arrives with average_done
		@(negedge clock);
		{sample_valid, average_done} = 2'h3;
		@(negedge clock);
		{sample_valid, average_done} = 2'h0;
		rd(4, d);
		check(d, expected(4));
		averaging_count = 3'h0;
		pulse(energy_overflow_event);
		rd(11, d);
		check(40'(d[11]), 40'h1);
		rd(9, d);
		rd(11, d);
		check(40'(d[11]), 40'h0);
		hold(raw_limit_fault, 5);
		$display("test overflow and transparent done");
		host.write(6'h0B, 16'h8000);
		hold(raw_limit_fault, 4);
		check(40'(alert_oe), 40'h1);
		rd(11, d);
		repeat (3) @(negedge clock);
		check(40'(alert_oe), 40'h0);
		pulse(sample_valid);
		rd(11, d);
		check(40'(d[1]), 40'h1);
		pulse(sample_valid);
		pulse(triggered_start);
		rd(11, d);
		check(40'(d[1]), 40'h0);
		host.write(6'h0B, 16'h2000);
		avg_limit_fault = 1'h1;
		repeat (5) @(negedge clock);
		check(40'(alert_oe), 40'h1);
		avg_limit_fault = 1'h0;
		raw_limit_fault = 1'h1;
		repeat (5) @(negedge clock);
		check(40'(alert_oe), 40'h0);
		raw_limit_fault = 1'h0;
		host.write(6'h0B, 16'h1000);
		repeat (5) @(negedge clock);
		check(40'(alert_oe), 40'h1);
		host.write(6'h0B, 16'h4000);
		pulse(sample_valid);
		repeat (5) @(negedge clock);
		check(40'(alert_oe), 40'h1);
		rd(11, d);
		check(40'(d[15:12]), 40'h4);
		$display("test alert modes done");
		finish_test();
	end
endmodule
